// ### hw/dtmf_defines.svh
`ifndef DTMF_DEFINES_SVH
`define DTMF_DEFINES_SVH
`define CLK_KHZ 250000
`define BURST_MS 51
`define BURST_CYCLES (`BURST_MS * `CLK_KHZ)
`define CNT_W 25
`define RS_DATA 1'b0
`define RS_CTRL 1'b1
`define SEL_B_BIT 3
`define CTRL_A_RST 4'h0
`define CTRL_B_RST 4'h0
`define STATUS_RST 4'h0
`define CODE_CLEAR 4'h0
`define DATA_W 4
`endif

// ### hw/dtmf_pkg.sv
package dtmf_pkg;
  typedef struct packed {
    logic second_control_select;
    logic irq_enable;
    logic call_progress_select;
    logic tone_output_enable;
  } ctrl_a_s;

  typedef struct packed {
    logic column_select;
    logic single_tone;
    logic receiver_powerdown;
    logic burst_disable;
  } ctrl_b_s;

  typedef struct packed {
    logic steering_absent;
    logic rx_full;
    logic tx_empty;
    logic irq;
  } status_s;

  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_TONE,
    BURST_PAUSE
  } burst_state_e;
endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Pins and synchronised copies.
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= RST;
      sync_o <= RST;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

// ### hw/burst_timer.sv
`timescale 1ns/1ps
`include "dtmf_defines.svh"
module burst_timer
  import dtmf_pkg::*;
#(
  parameter int BURST_CYCLES = `BURST_CYCLES,
  parameter int CNT_W = `CNT_W
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Control.
  input wire logic start_i,
  input wire logic long_i,
  input wire logic abort_i,
  // Status.
  output logic tone_o,
  output logic done_o
);
  burst_state_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] len_short;
  logic [CNT_W-1:0] len_long;
  logic long_reg;
  logic [CNT_W:0] elapsed_reg;

  assign len_short = CNT_W'(BURST_CYCLES - 1);
  assign len_long = CNT_W'(2 * BURST_CYCLES - 1);
  assign tone_o = (state_reg == BURST_TONE);
  assign done_o = ce_i && (state_reg == BURST_PAUSE) && (cnt_reg == '0) && !abort_i && !start_i;

  // ----------------------------------------------------------------
  // Burst and pause sequencing.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= BURST_IDLE;
      cnt_reg <= '0;
      long_reg <= 1'b0;
    end else if (ce_i) begin
      if (abort_i) begin
        state_reg <= BURST_IDLE;
      end else if (start_i) begin
        state_reg <= BURST_TONE;
        cnt_reg <= long_i ? len_long : len_short;
        long_reg <= long_i;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end else begin
        case (state_reg)
          BURST_TONE: begin
            state_reg <= BURST_PAUSE;
            cnt_reg <= long_reg ? len_long : len_short;
          end
          BURST_PAUSE: begin
            state_reg <= BURST_IDLE;
          end
          default: begin
            state_reg <= BURST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      elapsed_reg <= '0;
    end else if (ce_i) begin
      elapsed_reg <= start_i ? '0 : elapsed_reg + 1'b1;
    end
  end

  burst_length_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    done_o |-> elapsed_reg == (long_reg ? (CNT_W+1)'(4 * BURST_CYCLES - 1)
                                        : (CNT_W+1)'(2 * BURST_CYCLES - 1)))
    else $error("burst plus pause length wrong");

  burst_start_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && start_i && !abort_i |=> tone_o && !done_o)
    else $error("tone burst did not start");
endmodule

// ### hw/dtmf_transceiver_control_status.sv
`timescale 1ns/1ps
`include "dtmf_defines.svh"
module dtmf_transceiver_control_status
  import dtmf_pkg::*;
#(
  parameter int BURST_CYCLES = `BURST_CYCLES,
  parameter int CNT_W = `CNT_W
) (
  // Clock, reset and clock enable.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Microprocessor bus pins.
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic register_select_line_i,
  input wire logic [`DATA_W-1:0] data_i,
  output logic [`DATA_W-1:0] data_o,
  output logic data_oe_o,
  // Receiver side.
  input wire logic rx_valid_i,
  input wire logic [`DATA_W-1:0] rx_code_i,
  input wire logic steer_absent_i,
  input wire logic steer_present_i,
  input wire logic cp_square_i,
  // Transmitter side.
  output logic [`DATA_W-1:0] tx_code_o,
  output logic tone_on_o,
  output logic tone_out_en_o,
  output logic single_tone_o,
  output logic column_tone_o,
  // Power and mode.
  output logic receiver_powerdown_o,
  output logic call_progress_select_o,
  output logic osc_vref_powerdown_o,
  // Open-drain interrupt pin.
  output logic interrupt_tone_pin_o,
  output logic interrupt_tone_pin_oe_o
);
  // ----------------------------------------------------------------
  // Bus pin synchronisers and access strobes.
  // ----------------------------------------------------------------
  localparam int PIN_W = 4 + `DATA_W;
  logic [PIN_W-1:0] pins_s;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic rs_s;
  logic [`DATA_W-1:0] din_s;
  logic cs_q;
  logic rd_q;
  logic wr_q;
  logic rs_q;
  logic wr_done;
  logic rd_start;
  logic rd_end;
  logic ctrl_wr;
  logic tx_wr;
  logic status_rd_end;

  pin_sync #(
    .W(PIN_W),
    .RST({3'b111, 1'b0, `DATA_W'(0)})
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .async_i({cs_n_i, rd_n_i, wr_n_i, register_select_line_i, data_i}),
    .sync_o(pins_s)
  );

  assign {cs_s, rd_s, wr_s, rs_s} = pins_s[PIN_W-1:`DATA_W];
  assign din_s = pins_s[`DATA_W-1:0];

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      rs_q <= 1'b0;
    end else if (ce_i) begin
      cs_q <= cs_s;
      rd_q <= rd_s;
      wr_q <= wr_s;
      rs_q <= rs_s;
    end
  end

  function automatic logic rise(input logic now_v, input logic old_v);
    rise = now_v && !old_v;
  endfunction

  assign wr_done = rise(wr_s, wr_q) && !cs_q;
  assign rd_start = rise(rd_q, rd_s) && !cs_s;
  assign rd_end = rise(rd_s, rd_q) && !cs_q;
  assign ctrl_wr = wr_done && (rs_q == `RS_CTRL);
  assign tx_wr = wr_done && (rs_q == `RS_DATA);
  assign status_rd_end = rd_end && (rs_q == `RS_CTRL);

  // ----------------------------------------------------------------
  // Control registers sharing one address.
  // ----------------------------------------------------------------
  ctrl_a_s ctrl_a_reg;
  ctrl_b_s ctrl_b_reg;
  logic sel_b_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_a_reg <= `CTRL_A_RST;
      ctrl_b_reg <= `CTRL_B_RST;
      sel_b_reg <= 1'b0;
    end else if (ce_i && ctrl_wr) begin
      if (sel_b_reg) begin
        ctrl_b_reg <= din_s;
        sel_b_reg <= 1'b0;
      end else begin
        ctrl_a_reg <= din_s;
        sel_b_reg <= din_s[`SEL_B_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit data register and burst timer.
  // ----------------------------------------------------------------
  logic [`DATA_W-1:0] tx_code_reg;
  logic burst_on;
  logic timer_start;
  logic timer_abort;
  logic timer_tone;
  logic timer_done;

  assign burst_on = !ctrl_b_reg.burst_disable;
  assign timer_start = tx_wr && burst_on && ctrl_a_reg.tone_output_enable;
  assign timer_abort = !ctrl_a_reg.tone_output_enable || !burst_on;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_code_reg <= `CODE_CLEAR;
    end else if (ce_i) begin
      if (!ctrl_a_reg.tone_output_enable) begin
        tx_code_reg <= `CODE_CLEAR;
      end else if (tx_wr) begin
        tx_code_reg <= din_s;
      end
    end
  end

  burst_timer #(
    .BURST_CYCLES(BURST_CYCLES),
    .CNT_W(CNT_W)
  ) u_burst_timer (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .start_i(timer_start),
    .long_i(ctrl_a_reg.call_progress_select),
    .abort_i(timer_abort),
    .tone_o(timer_tone),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------
  // Status flags.
  // ----------------------------------------------------------------
  status_s status_reg;
  logic irq_reg;
  logic tx_empty_reg;
  logic rx_full_reg;
  logic steer_absent_reg;
  logic [`DATA_W-1:0] rx_code_reg;

  assign status_reg = {steer_absent_reg, rx_full_reg, tx_empty_reg, irq_reg};

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_empty_reg <= 1'b0;
    end else if (ce_i) begin
      if (!burst_on) begin
        tx_empty_reg <= 1'b0;
      end else if (timer_done) begin
        tx_empty_reg <= 1'b1;
      end else if (status_rd_end || tx_wr) begin
        tx_empty_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_full_reg <= 1'b0;
      rx_code_reg <= `CODE_CLEAR;
    end else if (ce_i) begin
      if (rx_valid_i) begin
        rx_full_reg <= 1'b1;
        rx_code_reg <= rx_code_i;
      end else if (status_rd_end) begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      if (rx_valid_i || (timer_done && burst_on)) begin
        irq_reg <= 1'b1;
      end else if (status_rd_end) begin
        irq_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      steer_absent_reg <= 1'b0;
    end else if (ce_i) begin
      if (steer_absent_i) begin
        steer_absent_reg <= 1'b1;
      end else if (steer_present_i) begin
        steer_absent_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and pin outputs.
  // ----------------------------------------------------------------
  logic irq_pin_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= `STATUS_RST;
    end else if (ce_i && rd_start) begin
      if (rs_s == `RS_CTRL) begin
        data_o <= status_reg;
      end else begin
        data_o <= rx_code_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_pin_reg <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_a_reg.irq_enable) begin
        irq_pin_reg <= 1'b0;
      end else if (ctrl_a_reg.call_progress_select) begin
        irq_pin_reg <= !cp_square_i;
      end else begin
        irq_pin_reg <= status_reg.irq;
      end
    end
  end

  assign data_oe_o = !cs_s && !rd_s;
  assign tx_code_o = tx_code_reg;
  assign tone_out_en_o = ctrl_a_reg.tone_output_enable;
  assign tone_on_o = ctrl_a_reg.tone_output_enable && (!burst_on || timer_tone);
  assign single_tone_o = ctrl_b_reg.single_tone;
  assign column_tone_o = ctrl_b_reg.single_tone && ctrl_b_reg.column_select;
  assign receiver_powerdown_o = ctrl_b_reg.receiver_powerdown;
  assign call_progress_select_o = ctrl_a_reg.call_progress_select;
  assign osc_vref_powerdown_o = !ctrl_a_reg.tone_output_enable
                                && ctrl_b_reg.receiver_powerdown;
  assign interrupt_tone_pin_o = 1'b0;
  assign interrupt_tone_pin_oe_o = irq_pin_reg;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence ctrl_b_write_s;
    ce_i && ctrl_wr && sel_b_reg;
  endsequence

  sequence status_read_s;
    ce_i && rd_start && rs_s == `RS_CTRL;
  endsequence

  ctrl_b_steer_a: assert property (ctrl_b_write_s |=> ctrl_b_reg == $past(din_s) && !sel_b_reg)
    else $error("second control write misrouted");

  tx_ready_set_a: assert property (ce_i && timer_done && burst_on |=> status_reg.tx_empty)
    else $error("transmit ready not set after pause");

  burst_off_clear_a: assert property (ce_i && !burst_on |=> !status_reg.tx_empty)
    else $error("transmit ready set outside burst mode");

  irq_flag_set_a: assert property (ce_i && rx_valid_i |=> status_reg.irq && status_reg.rx_full
                                   && rx_code_reg == $past(rx_code_i))
    else $error("receive event not flagged");

  read_snapshot_a: assert property (status_read_s |=> data_o == $past(status_reg))
    else $error("status read value wrong");

  read_clear_a: assert property (ce_i && status_rd_end && !rx_valid_i && !timer_done
                                 |=> !status_reg.irq && !status_reg.rx_full)
    else $error("flags not cleared after status read");

  steer_clear_a: assert property (ce_i && steer_present_i && !steer_absent_i
                                  |=> !status_reg.steering_absent)
    else $error("steering flag not cleared");

  tone_off_a: assert property (ce_i && !ctrl_a_reg.tone_output_enable && !ctrl_wr
                               |=> tx_code_o == `CODE_CLEAR && !tone_on_o)
    else $error("transmitter not powered down");

  irq_pin_a: assert property (ce_i && ctrl_a_reg.irq_enable && !ctrl_a_reg.call_progress_select
                              && status_reg.irq |=> interrupt_tone_pin_oe_o)
    else $error("interrupt pin not pulled low");
endmodule

// ### bench/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
  // Clock.
  input wire logic ref_clk_i,
  // Bus pins.
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic rs_o,
  output logic [3:0] data_o,
  input wire logic [3:0] data_i,
  input wire logic data_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    rs_o = 1'b0;
    data_o = 4'h5;
  end

  task automatic cycle_wait(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // One access per chip-select assertion, strobes held for several clocks.
  task automatic write_reg(input logic rs, input logic [3:0] d);
    @(negedge ref_clk_i);
    rs_o = rs;
    data_o = d;
    cs_n_o = 1'b0;
    wr_n_o = 1'b0;
    cycle_wait(4);
    wr_n_o = 1'b1;
    cycle_wait(3);
    cs_n_o = 1'b1;
    data_o = ~d;
    cycle_wait(4);
  endtask

  task automatic read_reg(input logic rs, output logic [3:0] q, output logic oe);
    @(negedge ref_clk_i);
    rs_o = rs;
    cs_n_o = 1'b0;
    rd_n_o = 1'b0;
    cycle_wait(6);
    q = data_i;
    oe = data_oe_i;
    rd_n_o = 1'b1;
    cycle_wait(3);
    cs_n_o = 1'b1;
    cycle_wait(4);
  endtask

  // Software reset after power-up.
  task automatic init_device(output logic [3:0] q0, output logic [3:0] q1);
    logic oe;
    read_reg(1'b1, q0, oe);
    write_reg(1'b1, 4'h0);
    write_reg(1'b1, 4'h0);
    write_reg(1'b1, 4'h8);
    write_reg(1'b1, 4'h0);
    read_reg(1'b1, q1, oe);
  endtask
endmodule

// ### bench/dtmf_transceiver_control_status_bench.sv
`timescale 1ns/1ps
module dtmf_transceiver_control_status_bench;
  import dtmf_pkg::*;
  localparam int L = 20;
  logic ref_clk_i;
  logic rstn_i;
  logic ce;
  logic cs_n, rd_n, wr_n, rs, doe;
  logic [3:0] din, dout, tx_code;
  logic rx_valid;
  logic [3:0] rx_code;
  logic steer_abs;
  logic steer_pres;
  logic cp_sq;
  logic tone_on, tone_en, single, column, rx_pd, cp_sel, osc_pd, pin, pin_oe;
  logic [3:0] q0, q1;
  int bad_count = 0;
  int checked = 0;
  int h, g;

  always #2 ref_clk_i = ~ref_clk_i;

  host_bus_model host (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .rs_o(rs), .data_o(din), .data_i(dout), .data_oe_i(doe));

  dtmf_transceiver_control_status #(.BURST_CYCLES(L)) dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .register_select_line_i(rs), .data_i(din), .data_o(dout),
    .data_oe_o(doe), .rx_valid_i(rx_valid), .rx_code_i(rx_code),
    .steer_absent_i(steer_abs), .steer_present_i(steer_pres), .cp_square_i(cp_sq),
    .tx_code_o(tx_code), .tone_on_o(tone_on), .tone_out_en_o(tone_en),
    .single_tone_o(single), .column_tone_o(column), .receiver_powerdown_o(rx_pd),
    .call_progress_select_o(cp_sel), .osc_vref_powerdown_o(osc_pd),
    .interrupt_tone_pin_o(pin), .interrupt_tone_pin_oe_o(pin_oe));

  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  task automatic final_report();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic status_is(input logic [3:0] exp);
    logic [3:0] q;
    logic oe;
    host.read_reg(1'b1, q, oe);
    check("status", q, exp);
    check("data_oe", {3'b0, oe}, 4'h1);
  endtask

  task automatic set_ctrl(input logic [3:0] a, input logic [3:0] b);
    host.write_reg(1'b1, a);
    host.write_reg(1'b1, b);
  endtask

  task automatic measure(output int high_n);
    int n;
    n = 0;
    high_n = 0;
    while (tone_on !== 1'b1 && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    while (tone_on === 1'b1 && high_n < 300) begin
      @(negedge ref_clk_i);
      high_n++;
    end
    if (n >= 300 || high_n >= 300) begin
      bad_count++;
      final_report();
    end
  endtask

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    rstn_i = 1'b0;
    ce = 1'b1;
    rx_valid = 1'b0;
    rx_code = 4'h0;
    steer_abs = 1'b0;
    steer_pres = 1'b0;
    cp_sq = 1'b1;
    repeat (16) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    host.cycle_wait(3);
    check("tone_on reset", {3'b0, tone_on}, 4'h0);
    check("osc_pd reset", {3'b0, osc_pd}, 4'h0);
    host.init_device(q0, q1);
    check("init status", q1, 4'h0);
    $display("test init done");
    for (int i = 0; i < 16; i++) begin
      set_ctrl(4'h8, i[3:0]);
      check("single", {3'b0, single}, {3'b0, i[2]});
      check("column", {3'b0, column}, {3'b0, i[2] & i[3]});
      check("rx_pd", {3'b0, rx_pd}, {3'b0, i[1]});
      check("osc_pd", {3'b0, osc_pd}, {3'b0, i[1]});
    end
    set_ctrl(4'h9, 4'h2);
    check("osc_pd tx on", {3'b0, osc_pd}, 4'h0);
    host.write_reg(1'b1, 4'h1);
    check("steer back", {3'b0, rx_pd}, 4'h1);
    check("no tone", {3'b0, tone_on}, 4'h0);
    ce = 1'b0;
    host.write_reg(1'b1, 4'h8);
    ce = 1'b1;
    host.cycle_wait(3);
    check("frozen write", {3'b0, tone_en}, 4'h1);
    check("frozen b", {3'b0, rx_pd}, 4'h1);
    $display("test control done");
    set_ctrl(4'hd, 4'h0);
    fork
      host.write_reg(1'b0, 4'h7);
      measure(h);
    join
    check("burst len", h[3:0], L[3:0]);
    check("burst len hi", h[7:4], L[7:4]);
    g = 0;
    while (pin_oe !== 1'b1 && g < 300) begin
      @(negedge ref_clk_i);
      g++;
    end
    if (g >= 300) begin
      bad_count++;
      final_report();
    end
    check("pause to ready", g[3:0], 4'(L + 1));
    check("pause hi", g[7:4], 4'((L + 1) >> 4));
    check("pin level", {3'b0, pin}, 4'h0);
    check("tx code", tx_code, 4'h7);
    status_is(4'h3);
    status_is(4'h0);
    check("pin released", {3'b0, pin_oe}, 4'h0);
    $display("test burst done");
    set_ctrl(4'hf, 4'h0);
    fork
      host.write_reg(1'b0, 4'h5);
      measure(h);
    join
    check("cp burst len", h[3:0], 4'(2 * L));
    check("cp burst hi", h[7:4], 4'((2 * L) >> 4));
    host.cycle_wait(20);
    status_is(4'h0);
    host.cycle_wait(15);
    status_is(4'h3);
    check("cp select", {3'b0, cp_sel}, 4'h1);
    cp_sq = 1'b0;
    host.cycle_wait(3);
    check("cp pin low", {3'b0, pin_oe}, 4'h1);
    cp_sq = 1'b1;
    host.cycle_wait(3);
    check("cp pin high", {3'b0, pin_oe}, 4'h0);
    $display("test call progress done");
    set_ctrl(4'h9, 4'h1);
    host.cycle_wait(50);
    check("steady tone", {3'b0, tone_on}, 4'h1);
    status_is(4'h0);
    host.write_reg(1'b1, 4'h0);
    check("tone off", {3'b0, tone_on}, 4'h0);
    check("tone float", {3'b0, tone_en}, 4'h0);
    check("tx cleared", tx_code, 4'h0);
    $display("test steady tone done");
    host.write_reg(1'b1, 4'h4);
    rx_code = 4'h9;
    rx_valid = 1'b1;
    @(negedge ref_clk_i);
    rx_valid = 1'b0;
    steer_abs = 1'b1;
    @(negedge ref_clk_i);
    steer_abs = 1'b0;
    host.cycle_wait(2);
    check("rx irq pin", {3'b0, pin_oe}, 4'h1);
    status_is(4'hd);
    host.read_reg(1'b0, q0, q1[0]);
    check("rx code", q0, 4'h9);
    status_is(4'h8);
    steer_pres = 1'b1;
    @(negedge ref_clk_i);
    steer_pres = 1'b0;
    status_is(4'h0);
    host.write_reg(1'b0, 4'h3);
    check("tx dropped", tx_code, 4'h0);
    $display("test receive done");
    final_report();
  end
endmodule
